// File: lgp_sink_driver.sv
// Sixteen-channel greyscale PWM sink driver end of the link.
// Assumes lgp_defines.svh is compiled first; all five link inputs are
// asynchronous to clock_in and are sampled through two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "lgp_defines.svh"

module lgp_sink_driver #(
	parameter int CHANNELS = `LGP_CHANNELS,
	parameter int GS_WIDTH = `LGP_GS_WIDTH
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	output logic [CHANNELS-1:0] sink_channel_out,
	output logic [`LGP_COUNT_WIDTH-1:0] pwm_count_out,
	output logic cycle_done_out,
	lgp_link_if.device link
);

	localparam int PACKET_BITS = CHANNELS * GS_WIDTH;
	localparam int PIN_COUNT = 5;
	localparam int PIN_BLANK = 0;
	localparam int PIN_GS_CLK = 1;
	localparam int PIN_SH_CLK = 2;
	localparam int PIN_SH_DATA = 3;
	localparam int PIN_LATCH = 4;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = {4'h0, `LGP_BLANK_RESET};

	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins_meta;
	logic [PIN_COUNT-1:0] pins_sync;
	logic [PIN_COUNT-1:0] pins_prev;
	logic blank;
	logic blank_fall;
	logic blank_rise;
	logic gs_rise;
	logic sh_rise;
	logic latch_rise;
	logic cycle_active;
	logic first_pending;
	logic greyscale_mode;
	logic [`LGP_COUNT_WIDTH-1:0] count;
	logic [PACKET_BITS-1:0] shift_reg;
	logic [GS_WIDTH-1:0] channel_brightness_value [CHANNELS];
	logic [CHANNELS-1:0] sink_on;
	logic [CHANNELS-1:0] match;
	logic [CHANNELS-1:0] lit;
	logic serial_out;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// True when a value equals the live count; count zero never matches
	function automatic logic value_hits(
		input logic [GS_WIDTH-1:0] value,
		input logic [`LGP_COUNT_WIDTH-1:0] cnt
	);
		value_hits = (cnt[`LGP_COUNT_WIDTH-1] == 1'b0) &&
			(cnt[GS_WIDTH-1:0] != '0) &&
			(cnt[GS_WIDTH-1:0] == value);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	assign pins_raw[PIN_BLANK] = link.output_blank_control;
	assign pins_raw[PIN_GS_CLK] = link.brightness_count_clock;
	assign pins_raw[PIN_SH_CLK] = link.serial_shift_clock;
	assign pins_raw[PIN_SH_DATA] = link.serial_chain_input;
	assign pins_raw[PIN_LATCH] = link.latch_strobe;

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			pins_meta <= PIN_RESET;
			pins_sync <= PIN_RESET;
			pins_prev <= PIN_RESET;
		end else if (clk_en_in) begin
			pins_meta <= pins_raw;
			pins_sync <= pins_meta;
			pins_prev <= pins_sync;
		end
	end

	assign blank = pins_sync[PIN_BLANK];
	assign blank_fall = pins_prev[PIN_BLANK] && !pins_sync[PIN_BLANK];
	assign blank_rise = !pins_prev[PIN_BLANK] && pins_sync[PIN_BLANK];
	assign gs_rise = !pins_prev[PIN_GS_CLK] && pins_sync[PIN_GS_CLK];
	assign sh_rise = !pins_prev[PIN_SH_CLK] && pins_sync[PIN_SH_CLK];
	assign latch_rise = !pins_prev[PIN_LATCH] && pins_sync[PIN_LATCH];

	// ----------------------------------------------------------------
	// Operating mode
	// ----------------------------------------------------------------
	// Dot correction input is not built, so greyscale mode is held
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			greyscale_mode <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Serial input and latch
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			shift_reg <= '0;
		end else if (clk_en_in && greyscale_mode) begin
			if (latch_rise) begin
				// Status readout is not built; the register reads back empty
				shift_reg <= '0;
			end else if (sh_rise) begin
				shift_reg <= {shift_reg[PACKET_BITS-2:0],
					pins_sync[PIN_SH_DATA]};
			end
		end
	end

	// Feeds the next driver of a cascade, as a flop
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			serial_out <= 1'b0;
		end else if (clk_en_in) begin
			serial_out <= shift_reg[PACKET_BITS-1];
		end
	end

	assign link.serial_chain_output = serial_out;

	// ----------------------------------------------------------------
	// Brightness registers
	// ----------------------------------------------------------------
	// Highest channel arrives first, each value most significant bit first
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_value
			always_ff @(posedge clock_in) begin
				if (!reset_n_in) begin
					channel_brightness_value[ch] <= '0;
				end else if (clk_en_in && latch_rise) begin
					channel_brightness_value[ch] <=
						shift_reg[ch*GS_WIDTH +: GS_WIDTH];
				end
			end
			assign match[ch] = value_hits(channel_brightness_value[ch],
				count);
			assign lit[ch] = (channel_brightness_value[ch] != '0);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Cycle control
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cycle_active <= 1'b0;
			first_pending <= 1'b0;
		end else if (clk_en_in) begin
			if (blank) begin
				cycle_active <= 1'b0;
				first_pending <= 1'b0;
			end else if (blank_fall) begin
				cycle_active <= 1'b1;
				first_pending <= 1'b1;
			end else if (gs_rise) begin
				first_pending <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Brightness counter
	// ----------------------------------------------------------------
	// Stops at 4096 so that stray pulses cannot restart the ramp
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			count <= '0;
		end else if (clk_en_in) begin
			if (blank) begin
				count <= '0;
			end else if (cycle_active && gs_rise &&
				count != `LGP_GS_PULSES) begin
				count <= count + 13'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sink outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			sink_on <= '0;
		end else if (clk_en_in) begin
			if (blank) begin
				sink_on <= '0;
			end else if (cycle_active && first_pending && gs_rise) begin
				sink_on <= lit;
			end else begin
				sink_on <= sink_on & ~match;
			end
		end
	end

	assign sink_channel_out = sink_on;
	assign pwm_count_out = count;

	// ----------------------------------------------------------------
	// Cycle completion
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cycle_done_out <= 1'b0;
		end else if (clk_en_in) begin
			cycle_done_out <= blank_rise &&
				(count == `LGP_GS_PULSES);
		end
	end

endmodule // lgp_sink_driver

`default_nettype wire

// File: lgp_defines.svh
// Constants shared by both ends of the greyscale PWM link.
// Assumes inclusion by bare name from files in the same folder.
`ifndef LGP_DEFINES_SVH
`define LGP_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define LGP_CHANNELS 16
`define LGP_GS_WIDTH 12
`define LGP_PACKET_BITS 192
`define LGP_COUNT_WIDTH 13

// ----------------------------------------------------------------
// Cycle and packet counts
// ----------------------------------------------------------------
`define LGP_GS_PULSES 13'h1000
`define LGP_PACKET_LAST 8'hC0

// ----------------------------------------------------------------
// Link timing, in clock_in cycles per half period of a link clock
// ----------------------------------------------------------------
`define LGP_HALF_PERIOD 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LGP_BLANK_RESET 1'h1

`endif

// File: lgp_pkg.sv
// Types used by the controller end of the greyscale PWM link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lgp_pkg;

	// ----------------------------------------------------------------
	// Controller sequence
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LGP_IDLE,
		LGP_SHIFT,
		LGP_LATCH,
		LGP_ARM,
		LGP_RUN
	} lgp_ctrl_state_t;

endpackage

`default_nettype wire

// File: lgp_link_if.sv
// Link between the display controller and the PWM sink driver.
// Assumes both ends run from clock domains of their own; no clock here.
`timescale 1ns/1ps
`default_nettype none

interface lgp_link_if;

	logic output_blank_control;
	logic brightness_count_clock;
	logic serial_shift_clock;
	logic serial_chain_input;
	logic latch_strobe;
	logic serial_chain_output;

	modport device (
		input output_blank_control,
		input brightness_count_clock,
		input serial_shift_clock,
		input serial_chain_input,
		input latch_strobe,
		output serial_chain_output
	);

	modport controller (
		output output_blank_control,
		output brightness_count_clock,
		output serial_shift_clock,
		output serial_chain_input,
		output latch_strobe,
		input serial_chain_output
	);

endinterface

`default_nettype wire

// File: lgp_controller.sv
// Display controller end: shifts one frame, latches it, runs one PWM cycle.
// Assumes lgp_defines.svh and lgp_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lgp_defines.svh"

module lgp_controller #(
	parameter int HALF_PERIOD = `LGP_HALF_PERIOD
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic load_in,
	input wire logic [`LGP_PACKET_BITS-1:0] frame_data_in,
	output logic ready_out,
	output logic done_out,
	lgp_link_if.controller link
);

	lgp_pkg::lgp_ctrl_state_t state;
	logic [7:0] half_cnt;
	logic step;
	logic [`LGP_PACKET_BITS-1:0] frame;
	logic [7:0] bits_sent;
	logic [`LGP_COUNT_WIDTH-1:0] pulses;
	logic blank;
	logic gs_clk;
	logic sh_clk;
	logic sh_data;
	logic latch;

	// ----------------------------------------------------------------
	// Link clock divider
	// ----------------------------------------------------------------
	assign step = (state != lgp_pkg::LGP_IDLE) &&
		(half_cnt == 8'(HALF_PERIOD - 1));

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			half_cnt <= 8'h00;
		end else if (clk_en_in) begin
			if (state == lgp_pkg::LGP_IDLE || step) begin
				half_cnt <= 8'h00;
			end else begin
				half_cnt <= half_cnt + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state <= lgp_pkg::LGP_IDLE;
			frame <= '0;
			bits_sent <= 8'h00;
			pulses <= '0;
			blank <= `LGP_BLANK_RESET;
			gs_clk <= 1'b0;
			sh_clk <= 1'b0;
			sh_data <= 1'b0;
			latch <= 1'b0;
			done_out <= 1'b0;
		end else if (clk_en_in) begin
			done_out <= 1'b0;
			case (state)
				lgp_pkg::LGP_IDLE: begin
					if (load_in) begin
						frame <= frame_data_in;
						sh_data <= frame_data_in[`LGP_PACKET_BITS-1];
						bits_sent <= 8'h00;
						pulses <= '0;
						state <= lgp_pkg::LGP_SHIFT;
					end
				end
				lgp_pkg::LGP_SHIFT: begin
					if (step) begin
						if (!sh_clk) begin
							sh_clk <= 1'b1;
							bits_sent <= bits_sent + 8'h01;
						// One packet per load: a chain of a single driver
						end else if (bits_sent == `LGP_PACKET_LAST) begin
							sh_clk <= 1'b0;
							state <= lgp_pkg::LGP_LATCH;
						end else begin
							sh_clk <= 1'b0;
							frame <= {frame[`LGP_PACKET_BITS-2:0], 1'b0};
							sh_data <= frame[`LGP_PACKET_BITS-2];
						end
					end
				end
				lgp_pkg::LGP_LATCH: begin
					if (step) begin
						if (!latch) begin
							latch <= 1'b1;
						end else begin
							latch <= 1'b0;
							state <= lgp_pkg::LGP_ARM;
						end
					end
				end
				lgp_pkg::LGP_ARM: begin
					if (step) begin
						blank <= 1'b0;
						state <= lgp_pkg::LGP_RUN;
					end
				end
				lgp_pkg::LGP_RUN: begin
					if (step) begin
						if (gs_clk) begin
							gs_clk <= 1'b0;
						end else if (pulses == `LGP_GS_PULSES) begin
							blank <= 1'b1;
							done_out <= 1'b1;
							state <= lgp_pkg::LGP_IDLE;
						end else begin
							gs_clk <= 1'b1;
							pulses <= pulses + 13'h0001;
						end
					end
				end
				default: begin
					state <= lgp_pkg::LGP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	assign ready_out = (state == lgp_pkg::LGP_IDLE);
	assign link.output_blank_control = blank;
	assign link.brightness_count_clock = gs_clk;
	assign link.serial_shift_clock = sh_clk;
	assign link.serial_chain_input = sh_data;
	assign link.latch_strobe = latch;

endmodule // lgp_controller

`default_nettype wire

// File: lgp_link_monitor.sv
// Concurrent checks on the greyscale PWM link wires.
// Assumes HALF_PERIOD matches the controller's half period.
`timescale 1ns/1ps
`default_nettype none

module lgp_link_monitor #(
	parameter int HALF_PERIOD = 4
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic output_blank_control,
	input wire logic brightness_count_clock,
	input wire logic serial_shift_clock,
	input wire logic serial_chain_input,
	input wire logic latch_strobe,
	input wire logic serial_chain_output
);
	// ----------------------------------------------------------------
	// Edge counters
	// ----------------------------------------------------------------
	logic cc_q;
	logic sc_q;
	logic [12:0] n_rise;
	logic [7:0] n_shift;
	logic [7:0] n_hi;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	always_ff @(posedge clock_in) begin
		cc_q <= brightness_count_clock;
		sc_q <= serial_shift_clock;
	end

	// Count clock rises within one unblanked period
	always_ff @(posedge clock_in) begin
		if (!reset_n_in || output_blank_control)
			n_rise <= 13'h0000;
		else if (brightness_count_clock && !cc_q)
			n_rise <= n_rise + 13'h0001;
	end

	// Shift clock rises since the last latch
	always_ff @(posedge clock_in) begin
		if (!reset_n_in || latch_strobe)
			n_shift <= 8'h00;
		else if (serial_shift_clock && !sc_q)
			n_shift <= n_shift + 8'h01;
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in || !latch_strobe)
			n_hi <= 8'h00;
		else
			n_hi <= n_hi + 8'h01;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_blank_no_count: assert property (
		output_blank_control |-> !brightness_count_clock)
		else $error("count clock high while blanked");
	chk_pulses_per_cycle: assert property (
		$rose(output_blank_control) |-> n_rise == 13'h1000)
		else $error("blank raised without 4096 count pulses");
	chk_blank_lead: assert property (
		$fell(output_blank_control) |-> !brightness_count_clock [*2])
		else $error("count clock too close to blank fall");
	chk_latch_width: assert property (
		$fell(latch_strobe) |-> n_hi == HALF_PERIOD)
		else $error("latch strobe width wrong");
	chk_frame_bits: assert property (
		$rose(latch_strobe) |-> n_shift == 8'hC0)
		else $error("latch not after 192 shift pulses");
	chk_run_quiet: assert property (
		!output_blank_control |-> !serial_shift_clock && !latch_strobe)
		else $error("shift or latch during PWM cycle");
	chk_count_hold: assert property (
		$changed(brightness_count_clock) |=>
		$stable(brightness_count_clock) [*2])
		else $error("count clock level too short");
	chk_data_setup: assert property (
		$rose(serial_shift_clock) |-> $stable(serial_chain_input))
		else $error("serial data moved at shift rise");
	chk_chain_cleared: assert property (
		!output_blank_control |-> !serial_chain_output)
		else $error("shift register not cleared after latch");

endmodule // lgp_link_monitor

`default_nettype wire

// File: tb_top.sv
// Self-checking bench: controller and sink driver joined by the link.
// Assumes lgp_defines.svh, lgp_pkg, interface and both ends compiled.
`timescale 1ns/1ps
`default_nettype none
`include "lgp_defines.svh"

module tb_top;
	localparam int HP = 3;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic load_in = 1'b0;
	logic [`LGP_PACKET_BITS-1:0] frame_data_in = '0;
	logic ready_out;
	logic done_out;
	logic cycle_done_out;
	logic [15:0] sink_channel_out;
	logic [12:0] pwm_count_out;
	logic [12:0] cnt_q = 13'h0000;
	logic [15:0] lfsr = 16'h003F;
	logic [11:0] val [16];
	logic [11:0] corner_v [5] = '{12'h000, 12'h001, 12'hFFF, 12'h002, 12'hFFE};
	int on_cnt [16];
	int base [16];
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_inc = 0;
	int n_done = 0;
	int base_inc;
	int base_done;

	lgp_link_if link ();
	lgp_controller #(.HALF_PERIOD(HP)) lgp_controller_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
		.load_in(load_in), .frame_data_in(frame_data_in),
		.ready_out(ready_out), .done_out(done_out), .link(link));
	lgp_sink_driver lgp_sink_driver_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
		.sink_channel_out(sink_channel_out), .pwm_count_out(pwm_count_out),
		.cycle_done_out(cycle_done_out), .link(link));
	lgp_link_monitor #(.HALF_PERIOD(HP)) lgp_link_monitor_inst (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.output_blank_control(link.output_blank_control),
		.brightness_count_clock(link.brightness_count_clock),
		.serial_shift_clock(link.serial_shift_clock),
		.serial_chain_input(link.serial_chain_input),
		.latch_strobe(link.latch_strobe),
		.serial_chain_output(link.serial_chain_output));

	always #5 clock_in = ~clock_in;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Cycles lit: on at count one, off one edge after count equals value
	function automatic int exp_on(input logic [11:0] v);
		return (v == 12'h000) ? 0 : (int'(v) - 1) * 2 * HP + 1;
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Sampled at the falling edge, where outputs are settled
	always @(negedge clock_in) begin
		cyc++;
		// Frozen cycles repeat the last state and are not counted
		for (int i = 0; i < 16; i++)
			if (clk_en_in)
				on_cnt[i] += sink_channel_out[i];
		if (pwm_count_out !== cnt_q && pwm_count_out !== 13'h0000) begin
			check("count step", pwm_count_out, cnt_q + 13'h0001);
			n_inc++;
		end
		cnt_q = pwm_count_out;
		n_done += cycle_done_out;
		if (cyc == 95000) begin
			n_fail++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	// Drops the clock enable for n cycles; sinks, count and both link clocks must hold
	task automatic freeze(input int n);
		logic [31:0] held;
		logic [31:0] after;
		held = {1'b0, sink_channel_out, pwm_count_out,
			link.brightness_count_clock, link.serial_shift_clock};
		clk_en_in <= 1'b0;
		repeat (n) @(negedge clock_in);
		after = {1'b0, sink_channel_out, pwm_count_out,
			link.brightness_count_clock, link.serial_shift_clock};
		check("freeze hold", after, held);
		clk_en_in <= 1'b1;
	endtask

	task automatic do_reset();
		@(negedge clock_in);
		reset_n_in = 1'b0;
		repeat (4) @(negedge clock_in);
		reset_n_in = 1'b1;
		@(negedge clock_in);
		check("reset sinks", sink_channel_out, 16'h0000);
		check("reset count", pwm_count_out, 13'h0000);
		check("reset ready", ready_out, 1'b1);
	endtask

	task automatic start_frame(input bit corner);
		@(negedge clock_in);
		for (int i = 0; i < 16; i++) begin
			lfsr = next_rand(lfsr);
			val[i] = lfsr[11:0];
			if (corner && i < 5)
				val[i] = corner_v[i];
			frame_data_in[12*i +: 12] = val[i];
		end
		check("idle sinks", sink_channel_out, 16'h0000);
		check("idle count", pwm_count_out, 13'h0000);
		@(posedge clock_in);
		base = on_cnt;
		base_inc = n_inc;
		base_done = n_done;
		@(negedge clock_in);
		load_in = 1'b1;
		@(negedge clock_in);
		load_in = 1'b0;
		repeat (20) @(negedge clock_in);
		// A load while busy must leave the running frame untouched
		frame_data_in = ~frame_data_in;
		load_in = 1'b1;
		check("busy ready", ready_out, 1'b0);
		@(negedge clock_in);
		load_in = 1'b0;
		freeze(9);
	endtask

	task automatic finish_frame();
		int w;
		repeat (2000) @(negedge clock_in);
		freeze(8 + int'(lfsr[2:0]));
		for (w = 0; w < 30000 && done_out !== 1'b1; w++)
			@(negedge clock_in);
		check("done seen", done_out, 1'b1);
		repeat (8) @(negedge clock_in);
		for (int i = 0; i < 16; i++)
			check("on cycles", on_cnt[i] - base[i], exp_on(val[i]));
		check("count steps", n_inc - base_inc, 4096);
		check("cycle done", n_done - base_done, 1);
		check("end count", pwm_count_out, 13'h0000);
		check("end sinks", sink_channel_out, 16'h0000);
		check("chain out", link.serial_chain_output, 1'b0);
	endtask

	initial begin
		do_reset();
		start_frame(1'b1);
		finish_frame();
		start_frame(1'b0);
		finish_frame();
		start_frame(1'b0);
		repeat (3000) @(negedge clock_in);
		do_reset();
		start_frame(1'b0);
		finish_frame();
		end_sim();
	end

endmodule // tb_top

`default_nettype wire
